//--- src/tpgw_pkg.sv
package tpgw_pkg;

    // Data-memory addresses of the port registers
    localparam logic [7:0] TPGW_ADDR_A_DATA = 8'h00;
    localparam logic [7:0] TPGW_ADDR_A_DIR  = 8'h01;
    localparam logic [7:0] TPGW_ADDR_A_PU   = 8'h02;
    localparam logic [7:0] TPGW_ADDR_A_WAKE = 8'h03;
    localparam logic [7:0] TPGW_ADDR_B_DATA = 8'h04;
    localparam logic [7:0] TPGW_ADDR_B_DIR  = 8'h05;
    localparam logic [7:0] TPGW_ADDR_B_PU   = 8'h06;
    localparam logic [7:0] TPGW_ADDR_C_DATA = 8'h07;
    localparam logic [7:0] TPGW_ADDR_C_DIR  = 8'h08;
    localparam logic [7:0] TPGW_ADDR_C_PU   = 8'h09;

    // Power-on and normal watchdog reset values
    localparam logic [7:0] TPGW_RST_DATA = 8'hFF;
    localparam logic [7:0] TPGW_RST_DIR  = 8'hFF;
    localparam logic [7:0] TPGW_RST_PU   = 8'h00;
    localparam logic [7:0] TPGW_RST_WAKE = 8'h00;

    // Implemented-bit mask of the six-bit third port
    localparam logic [7:0] TPGW_C_MASK = 8'h3F;

    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } tpgw_mem_req_t;

    typedef struct packed {
        logic [7:0] dout;
        logic [7:0] oe;
        logic [7:0] pull;
    } tpgw_pin_drv_t;

    typedef enum logic {
        TPGW_RUN,
        TPGW_HALT
    } tpgw_pwr_t;

endpackage

//--- src/tpgw_gpio.sv
`timescale 1ns/1ns

module tpgw_gpio #(
    parameter int WIDTH_A = 8,
    parameter int WIDTH_B = 8,
    parameter int WIDTH_C = 6
) (
    // Clock and reset
    input  wire logic                   ref_clk,
    input  wire logic                   rst,
    input  wire logic                   clk_en,
    // Watchdog time-out reset, taken synchronously
    input  wire logic                   wdt_reset,
    // Processor data-memory access
    input  wire tpgw_pkg::tpgw_mem_req_t mem_req,
    output tpgw_pkg::tpgw_pin_drv_t     unused_drv_r,
    output logic [7:0]                  rdata_r,
    // Power control
    input  wire logic                   halt_exec,
    output logic                        halted_r,
    output logic                        wake_r,
    // Pin function select of the first port, 1 = general-purpose I/O
    input  wire logic [7:0]             a_gpio_sel,
    // Pins
    input  wire logic [7:0]             a_pin_in,
    input  wire logic [7:0]             b_pin_in,
    input  wire logic [7:0]             c_pin_in,
    output tpgw_pkg::tpgw_pin_drv_t     a_drv_r,
    output tpgw_pkg::tpgw_pin_drv_t     b_drv_r,
    output tpgw_pkg::tpgw_pin_drv_t     c_drv_r
);
    import tpgw_pkg::*;

    // Elaboration checks: the address decode and the masks
    // below serve only this port shape
    if (WIDTH_A != 8) begin : g_bad_width_a
        $error("tpgw_gpio: first port must be 8 bits wide");
    end
    if (WIDTH_B != 8) begin : g_bad_width_b
        $error("tpgw_gpio: second port must be 8 bits wide");
    end
    if (WIDTH_C != 6) begin : g_bad_width_c
        $error("tpgw_gpio: third port must be 6 bits wide");
    end
    if (TPGW_C_MASK != 8'((1 << WIDTH_C) - 1)) begin : g_bad_mask
        $error("tpgw_gpio: third port mask does not match its width");
    end

    // Register state
    logic [7:0] a_data_r, a_dir_r, a_pu_r, a_wake_r;
    logic [7:0] b_data_r, b_dir_r, b_pu_r;
    logic [7:0] c_data_r, c_dir_r, c_pu_r;
    logic [7:0] a_data_nxt, a_dir_nxt, a_pu_nxt, a_wake_nxt;
    logic [7:0] b_data_nxt, b_dir_nxt, b_pu_nxt;
    logic [7:0] c_data_nxt, c_dir_nxt, c_pu_nxt;
    logic [7:0] rdata_nxt;
    logic [7:0] a_prev_r, a_prev_nxt;
    tpgw_pwr_t  pwr_r, pwr_nxt;
    logic       wake_nxt, halted_nxt;
    // Per-pin qualified falling edge of the first port
    logic [7:0] a_fall;
    tpgw_pin_drv_t a_drv_nxt, b_drv_nxt, c_drv_nxt;

    // Read value per pin: live level for inputs, latch for outputs
    function automatic logic [7:0] tpgw_rd(input logic [7:0] dir,
                                           input logic [7:0] latch,
                                           input logic [7:0] pin);
        tpgw_rd = (dir & pin) | (~dir & latch);
    endfunction

    // Pin drive: direction 0 drives, pull-high only on inputs
    function automatic tpgw_pin_drv_t tpgw_drv(input logic [7:0] dir,
                                               input logic [7:0] latch,
                                               input logic [7:0] pu);
        tpgw_pin_drv_t d;
        d.dout = latch;
        d.oe   = ~dir;
        d.pull = pu & dir;
        tpgw_drv = d;
    endfunction

    always_comb begin
        a_data_nxt = a_data_r;
        a_dir_nxt  = a_dir_r;
        a_pu_nxt   = a_pu_r;
        a_wake_nxt = a_wake_r;
        b_data_nxt = b_data_r;
        b_dir_nxt  = b_dir_r;
        b_pu_nxt   = b_pu_r;
        c_data_nxt = c_data_r;
        c_dir_nxt  = c_dir_r;
        c_pu_nxt   = c_pu_r;
        // halted watchdog keeps registers
        // A watchdog in run wins over a write in the same cycle
        if (wdt_reset && pwr_r == TPGW_RUN) begin
            a_data_nxt = TPGW_RST_DATA;
            a_dir_nxt  = TPGW_RST_DIR;
            a_pu_nxt   = TPGW_RST_PU;
            a_wake_nxt = TPGW_RST_WAKE;
            b_data_nxt = TPGW_RST_DATA;
            b_dir_nxt  = TPGW_RST_DIR;
            b_pu_nxt   = TPGW_RST_PU;
            c_data_nxt = TPGW_RST_DATA & TPGW_C_MASK;
            c_dir_nxt  = TPGW_RST_DIR & TPGW_C_MASK;
            c_pu_nxt   = TPGW_RST_PU & TPGW_C_MASK;
        end else if (mem_req.wr) begin
            if (mem_req.addr == TPGW_ADDR_A_DATA) begin
                a_data_nxt = mem_req.wdata;
            end else if (mem_req.addr == TPGW_ADDR_A_DIR) begin
                a_dir_nxt = mem_req.wdata;
            end else if (mem_req.addr == TPGW_ADDR_A_PU) begin
                a_pu_nxt = mem_req.wdata;
            end else if (mem_req.addr == TPGW_ADDR_A_WAKE) begin
                a_wake_nxt = mem_req.wdata;
            end else if (mem_req.addr == TPGW_ADDR_B_DATA) begin
                b_data_nxt = mem_req.wdata;
            end else if (mem_req.addr == TPGW_ADDR_B_DIR) begin
                b_dir_nxt = mem_req.wdata;
            end else if (mem_req.addr == TPGW_ADDR_B_PU) begin
                b_pu_nxt = mem_req.wdata;
            end else if (mem_req.addr == TPGW_ADDR_C_DATA) begin
                c_data_nxt = mem_req.wdata & TPGW_C_MASK;
            end else if (mem_req.addr == TPGW_ADDR_C_DIR) begin
                c_dir_nxt = mem_req.wdata & TPGW_C_MASK;
            end else if (mem_req.addr == TPGW_ADDR_C_PU) begin
                c_pu_nxt = mem_req.wdata & TPGW_C_MASK;
            end
        end
    end

    // Read group: a read in the cycle of a write sees the old value
    always_comb begin
        rdata_nxt = rdata_r;
        if (mem_req.rd) begin
            if (mem_req.addr == TPGW_ADDR_A_DATA) begin
                rdata_nxt = tpgw_rd(a_dir_r, a_data_r, a_pin_in);
            end else if (mem_req.addr == TPGW_ADDR_A_DIR) begin
                rdata_nxt = a_dir_r;
            end else if (mem_req.addr == TPGW_ADDR_A_PU) begin
                rdata_nxt = a_pu_r;
            end else if (mem_req.addr == TPGW_ADDR_A_WAKE) begin
                rdata_nxt = a_wake_r;
            end else if (mem_req.addr == TPGW_ADDR_B_DATA) begin
                rdata_nxt = tpgw_rd(b_dir_r, b_data_r, b_pin_in);
            end else if (mem_req.addr == TPGW_ADDR_B_DIR) begin
                rdata_nxt = b_dir_r;
            end else if (mem_req.addr == TPGW_ADDR_B_PU) begin
                rdata_nxt = b_pu_r;
            end else if (mem_req.addr == TPGW_ADDR_C_DATA) begin
                rdata_nxt = tpgw_rd(c_dir_r, c_data_r, c_pin_in) & TPGW_C_MASK;
            end else if (mem_req.addr == TPGW_ADDR_C_DIR) begin
                rdata_nxt = c_dir_r;
            end else if (mem_req.addr == TPGW_ADDR_C_PU) begin
                rdata_nxt = c_pu_r;
            end else begin
                // Unmapped locations belong to other blocks
                rdata_nxt = 8'h00;
            end
        end
    end

    always_comb begin
        a_drv_nxt = tpgw_drv(a_dir_nxt, a_data_nxt, a_pu_nxt);
        b_drv_nxt = tpgw_drv(b_dir_nxt, b_data_nxt, b_pu_nxt);
        // absent pins count as inputs, so they never drive
        c_drv_nxt = tpgw_drv(c_dir_nxt | ~TPGW_C_MASK, c_data_nxt, c_pu_nxt);
    end

    for (genvar i = 0; i < WIDTH_A; i++) begin : g_wake
        // The previous sample is kept in every state, so an edge
        // right after the halt is not lost
        assign a_fall[i] = a_prev_r[i] & ~a_pin_in[i] & a_wake_r[i] & a_gpio_sel[i];
    end

    // Power state and wake detection
    always_comb begin
        pwr_nxt    = pwr_r;
        wake_nxt   = 1'b0;
        a_prev_nxt = a_pin_in;
        case (pwr_r)
            TPGW_RUN: begin
                if (halt_exec) begin
                    pwr_nxt = TPGW_HALT;
                end
            end
            TPGW_HALT: begin
                if (|a_fall) begin
                    pwr_nxt  = TPGW_RUN;
                    wake_nxt = 1'b1;
                end else if (wdt_reset) begin
                    // Watchdog also ends the halt, registers untouched
                    pwr_nxt = TPGW_RUN;
                end
            end
            default: pwr_nxt = TPGW_RUN;
        endcase
        halted_nxt = (pwr_nxt == TPGW_HALT);
    end

    // Register group
    // A watchdog in halt and a low clk_en both leave it as it is
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            a_data_r <= TPGW_RST_DATA;
            a_dir_r  <= TPGW_RST_DIR;
            a_pu_r   <= TPGW_RST_PU;
            a_wake_r <= TPGW_RST_WAKE;
            b_data_r <= TPGW_RST_DATA;
            b_dir_r  <= TPGW_RST_DIR;
            b_pu_r   <= TPGW_RST_PU;
            c_data_r <= TPGW_RST_DATA & TPGW_C_MASK;
            c_dir_r  <= TPGW_RST_DIR & TPGW_C_MASK;
            c_pu_r   <= TPGW_RST_PU & TPGW_C_MASK;
        end else if (clk_en) begin
            a_data_r <= a_data_nxt;
            a_dir_r  <= a_dir_nxt;
            a_pu_r   <= a_pu_nxt;
            a_wake_r <= a_wake_nxt;
            b_data_r <= b_data_nxt;
            b_dir_r  <= b_dir_nxt;
            b_pu_r   <= b_pu_nxt;
            c_data_r <= c_data_nxt;
            c_dir_r  <= c_dir_nxt;
            c_pu_r   <= c_pu_nxt;
        end
    end

    // Read group: rdata_r holds until the next read
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rdata_r <= '0;
        end else if (clk_en) begin
            rdata_r <= rdata_nxt;
        end
    end

    // Power group: wake_r is a one-cycle pulse
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            // Starts high; a pin low out of reset never counts as a fall, as a_wake_r resets to zero
            a_prev_r <= '1;
            pwr_r    <= TPGW_RUN;
            wake_r   <= 1'b0;
            halted_r <= 1'b0;
        end else if (clk_en) begin
            a_prev_r <= a_prev_nxt;
            pwr_r    <= pwr_nxt;
            wake_r   <= wake_nxt;
            halted_r <= halted_nxt;
        end
    end

    // Pin drive group, registered so that pins never see decode glitches
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            a_drv_r      <= tpgw_drv(TPGW_RST_DIR, TPGW_RST_DATA, TPGW_RST_PU);
            b_drv_r      <= tpgw_drv(TPGW_RST_DIR, TPGW_RST_DATA, TPGW_RST_PU);
            c_drv_r      <= tpgw_drv(TPGW_RST_DIR | ~TPGW_C_MASK, TPGW_RST_DATA & TPGW_C_MASK,
                                     TPGW_RST_PU & TPGW_C_MASK);
            // Spare drive port, held at zero
            unused_drv_r <= '0;
        end else if (clk_en) begin
            a_drv_r      <= a_drv_nxt;
            b_drv_r      <= b_drv_nxt;
            c_drv_r      <= c_drv_nxt;
            unused_drv_r <= '0;
        end
    end

endmodule

//--- verification/tpgw_gpio_monitor.sv
`timescale 1ns/1ns
module tpgw_gpio_monitor (
    // Clock, reset and control
    input wire logic                    ref_clk,
    input wire logic                    rst,
    input wire logic                    clk_en,
    input wire logic                    wdt_reset,
    input wire logic                    halt_exec,
    input wire tpgw_pkg::tpgw_mem_req_t mem_req,
    input wire logic [7:0]              a_gpio_sel,
    input wire logic [7:0]              a_pin_in,
    // Watched outputs
    input wire logic                    halted_r,
    input wire logic                    wake_r,
    input wire tpgw_pkg::tpgw_pin_drv_t a_drv_r,
    input wire tpgw_pkg::tpgw_pin_drv_t b_drv_r,
    input wire tpgw_pkg::tpgw_pin_drv_t c_drv_r
);
    import tpgw_pkg::*;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    a_c_top_zero: assert property (
        {c_drv_r.oe[7:6], c_drv_r.pull[7:6], c_drv_r.dout[7:6]} == 6'h00)
        else $error("third port top bits active");
    a_pull_input: assert property (
        ((a_drv_r.pull & a_drv_r.oe) | (b_drv_r.pull & b_drv_r.oe) |
         (c_drv_r.pull & c_drv_r.oe)) == 8'h00)
        else $error("pull-high on a driven pin");
    a_halt_entry: assert property (clk_en && !halted_r && halt_exec |=> halted_r)
        else $error("halt not entered");
    a_wake_cause: assert property (wake_r |-> $past(halted_r) && !halted_r &&
        (($past(a_gpio_sel) & $past(a_pin_in, 2) & ~$past(a_pin_in)) != 8'h00))
        else $error("wake without falling edge in halt");
    a_wake_pulse: assert property (clk_en && wake_r |=> !wake_r)
        else $error("wake pulse too long");
    a_freeze_hold: assert property (!clk_en |=> $stable(halted_r) &&
        $stable(a_drv_r) && $stable(b_drv_r) && $stable(c_drv_r))
        else $error("state changed while clock enable low");
    a_wdt_halt: assert property (clk_en && halted_r && wdt_reset && !mem_req.wr |=>
        !halted_r && !wake_r && $stable(a_drv_r) && $stable(b_drv_r) && $stable(c_drv_r))
        else $error("watchdog in halt changed ports");
    a_wdt_run: assert property (clk_en && !halted_r && wdt_reset |=> a_drv_r.oe == 8'h00 &&
        a_drv_r.dout == 8'hFF && c_drv_r.dout == 8'h3F && b_drv_r.pull == 8'h00)
        else $error("watchdog in run missed reset values");
    a_drv_hold: assert property (!mem_req.wr && !wdt_reset |=>
        $stable(a_drv_r) && $stable(b_drv_r) && $stable(c_drv_r))
        else $error("pin drive changed without write");
endmodule

bind tpgw_gpio tpgw_gpio_monitor u_mon (.ref_clk, .rst, .clk_en, .wdt_reset, .halt_exec, .mem_req,
    .a_gpio_sel, .a_pin_in, .halted_r, .wake_r, .a_drv_r, .b_drv_r, .c_drv_r);

//--- verification/tpgw_pins.sv
`timescale 1ns/1ns
module tpgw_pins (
    // Clock
    input  wire logic                    ref_clk,
    // Device drive and external switches
    input  wire tpgw_pkg::tpgw_pin_drv_t drv,
    input  wire logic [7:0]              ext_val,
    input  wire logic [7:0]              ext_en,
    // Pad level
    output logic [7:0]                   pin
);
    import tpgw_pkg::*;
    logic [7:0] float_r = 8'h55;
    // A floating pad wanders, so a lost pull-high cannot read as a clean one
    always @(posedge ref_clk) float_r <= ~float_r;
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pin[i] = drv.oe[i] ? drv.dout[i] : ext_en[i] ? ext_val[i] : drv.pull[i] | float_r[i];
        end
    end
endmodule

//--- verification/tb_tpgw_gpio.sv
`timescale 1ns/1ns
module tb_tpgw_gpio;
    import tpgw_pkg::*;
    logic            ref_clk    = 1'b0;
    logic            rst        = 1'b1;
    logic            clk_en     = 1'b1;
    tpgw_pin_drv_t   spare;
    logic            wdt_reset  = 1'b0;
    logic            halt_exec  = 1'b0;
    logic [7:0]      a_gpio_sel = 8'hFF;
    logic [2:0][7:0] ext_val    = '1;
    logic [2:0][7:0] ext_en     = '1;
    logic [2:0][7:0] pin;
    tpgw_mem_req_t   mem_req    = '0;
    tpgw_pin_drv_t   drv [3];
    logic [7:0]      rdata_r;
    logic            halted_r;
    logic            wake_r;
    logic [7:0]      regs [10];
    logic [31:0]     seed       = 32'hDCF3;
    int              mismatches = 0;
    int              tests_run  = 0;

    tpgw_gpio u_dut (.ref_clk, .rst, .clk_en, .wdt_reset, .mem_req, .unused_drv_r(spare),
        .rdata_r, .halt_exec, .halted_r, .wake_r, .a_gpio_sel, .a_pin_in(pin[0]),
        .b_pin_in(pin[1]), .c_pin_in(pin[2]), .a_drv_r(drv[0]), .b_drv_r(drv[1]),
        .c_drv_r(drv[2]));
    for (genvar p = 0; p < 3; p++) begin : g_pad
        tpgw_pins u_pad (.ref_clk, .drv(drv[p]), .ext_val(ext_val[p]), .ext_en(ext_en[p]),
            .pin(pin[p]));
    end

    initial forever #50 ref_clk = ~ref_clk;

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [7:0] msk(int a);
        return (a >= 7) ? 8'h3F : 8'hFF;
    endfunction
    function automatic int base(int p);
        return (p == 0) ? 0 : (p == 1) ? 4 : 7;
    endfunction
    // Input bits show the switch level, output bits the latch
    function automatic logic [7:0] exp_rd(int a);
        int p;
        p = (a < 4) ? 0 : (a < 7) ? 1 : 2;
        if (a > 9) return 8'h00;
        if (a != base(p)) return regs[a];
        return ((regs[a] & ~regs[a + 1]) | (ext_val[p] & regs[a + 1])) & msk(a);
    endfunction

    task automatic cmp8(string what, logic [7:0] e, logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic wr(int a, logic [7:0] d);
        @(posedge ref_clk) mem_req <= '{1'b0, 1'b1, 8'(a), d};
        @(posedge ref_clk) mem_req <= '0;
        if (a < 10) regs[a] = d & msk(a);
    endtask
    task automatic rd(int a, logic [7:0] e);
        @(posedge ref_clk) mem_req <= '{1'b1, 1'b0, 8'(a), 8'h00};
        @(posedge ref_clk) mem_req <= '0;
        @(negedge ref_clk) cmp8("rdata", e, rdata_r);
    endtask
    task automatic rd_all();
        for (int a = 0; a < 12; a++) rd(a, exp_rd(a));
    endtask
    task automatic set_rst();
        for (int a = 0; a < 10; a++)
            regs[a] = (a == 2 || a == 3 || a == 6 || a == 9) ? 8'h00 : msk(a);
    endtask
    task automatic chk_drv();
        for (int p = 0; p < 3; p++) begin
            cmp8("oe", ~regs[base(p) + 1] & msk(base(p)), drv[p].oe);
            cmp8("dout", regs[base(p)], drv[p].dout);
            cmp8("pull", regs[base(p) + 2] & regs[base(p) + 1], drv[p].pull);
        end
        cmp8("spare", 8'h00, 8'(|spare));
    endtask
    task automatic halt();
        @(posedge ref_clk) halt_exec <= 1'b1;
        @(posedge ref_clk) halt_exec <= 1'b0;
        @(negedge ref_clk) cmp8("halted", 8'h01, 8'(halted_r));
    endtask
    task automatic test_done();
        $display("tests_run %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        int a;
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        set_rst();
        rd_all();
        chk_drv();
        for (int n = 0; n < 300; n++) begin
            @(posedge ref_clk) ext_val <= 24'(xs());
            wr(int'(xs() % 12), 8'(xs()));
            a = int'(xs() % 12);
            rd(a, exp_rd(a));
        end
        chk_drv();
        for (int p = 0; p < 3; p++) begin
            wr(base(p) + 1, 8'hFF);
            wr(base(p) + 2, 8'hFF);
            @(posedge ref_clk) ext_en[p] <= 8'h00;
            rd(base(p), msk(base(p)));
            @(posedge ref_clk) ext_en[p] <= 8'hFF;
        end
        // Frozen enable: a direction write must not land
        @(posedge ref_clk) clk_en <= 1'b0;
        @(posedge ref_clk) mem_req <= '{1'b0, 1'b1, TPGW_ADDR_B_DIR, 8'h00};
        @(posedge ref_clk) mem_req <= '0;
        @(posedge ref_clk) clk_en <= 1'b1;
        @(negedge ref_clk) chk_drv();
        wr(TPGW_ADDR_A_WAKE, 8'h05);
        @(posedge ref_clk) ext_val[0] <= 8'hFF;
        a_gpio_sel <= 8'hFB;
        halt();
        @(posedge ref_clk) ext_val[0] <= 8'hF9;
        repeat (3) @(negedge ref_clk);
        cmp8("wake", 8'h00, 8'(wake_r));
        @(posedge ref_clk) ext_val[0] <= 8'hF8;
        repeat (2) @(negedge ref_clk);
        cmp8("wake", 8'h01, 8'(wake_r));
        cmp8("halted", 8'h00, 8'(halted_r));
        @(posedge ref_clk) ext_val[0] <= 8'hFF;
        halt();
        @(posedge ref_clk) wdt_reset <= 1'b1;
        @(posedge ref_clk) wdt_reset <= 1'b0;
        @(negedge ref_clk) cmp8("halted", 8'h00, 8'(halted_r | wake_r));
        chk_drv();
        rd_all();
        @(posedge ref_clk) wdt_reset <= 1'b1;
        @(posedge ref_clk) wdt_reset <= 1'b0;
        @(negedge ref_clk) set_rst();
        chk_drv();
        rd_all();
        test_done();
    end

    initial begin
        #1000000;
        mismatches++;
        test_done();
    end
endmodule
